// [common/tpp_pkg.sv]
package tpp_pkg;

  // ************************************************************
  // Register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CCC = 8'h04;
  localparam logic [7:0] OFF_PRESCALE = 8'h08;
  localparam logic [7:0] OFF_OUTCTL = 8'h0C;
  localparam logic [7:0] OFF_CCA = 8'h10;
  localparam logic [7:0] OFF_CCB = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CCC_A_CAPTURE = 0;
  localparam int CCC_B_CAPTURE = 1;
  localparam int PRS_CLK_LO = 0;
  localparam int PRS_EDGE_A_LO = 4;
  localparam int PRS_EDGE_B_LO = 6;
  localparam int OUT_ENABLE = 0;
  localparam int OUT_A_INVERT = 1;
  localparam int OUT_FORCE_HIGH = 2;
  localparam int OUT_FORCE_LOW = 3;
  localparam int OUT_B_INVERT = 4;
  localparam int STS_OVERFLOW = 0;

  // ************************************************************
  // Encodings and reset values
  // ************************************************************
  localparam logic [1:0] MODE_CODE_STOP = 2'h0;
  localparam logic [1:0] MODE_CODE_FREE = 2'h1;
  localparam logic [1:0] MODE_CODE_CLEAR_A = 2'h2;
  localparam logic [1:0] MODE_CODE_RESTART = 2'h3;
  localparam logic [1:0] CLK_SEL_DIV1 = 2'h0;
  localparam logic [1:0] CLK_SEL_DIV4 = 2'h1;
  localparam logic [1:0] CLK_SEL_DIV256 = 2'h2;
  localparam logic [1:0] CLK_SEL_EDGE_A = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [7:0] DIV4_TERM = 8'h03;
  localparam logic [7:0] DIV256_TERM = 8'hFF;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    TPP_STOP,
    TPP_FREE,
    TPP_CLEAR_A,
    TPP_RESTART
  } tpp_mode_type;

endpackage : tpp_pkg

// [hw/tpp_timer.sv]
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
module tpp_timer (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic trigger_input_a,
  input wire logic trigger_input_b,
  output logic timer_output_pin,
  // Events
  output logic match_irq_a,
  output logic capture_irq_b
);
  import tpp_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                    input logic fall);
    case (sel)
      EDGE_FALL: edge_hit = fall;
      EDGE_RISE: edge_hit = rise;
      EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  function automatic tpp_mode_type mode_of(input logic [1:0] code);
    case (code)
      MODE_CODE_FREE: mode_of = TPP_FREE;
      MODE_CODE_CLEAR_A: mode_of = TPP_CLEAR_A;
      MODE_CODE_RESTART: mode_of = TPP_RESTART;
      default: mode_of = TPP_STOP;
    endcase
  endfunction : mode_of

  logic [1:0] timer_mode_control_q;
  logic [1:0] capture_compare_control_q;
  logic [7:0] prescaler_edge_select_q;
  logic [4:0] output_control_q;
  logic [15:0] compare_capture_a_q;
  logic [15:0] compare_capture_b_q;
  logic [15:0] timer_count_q;
  logic overflow_flag_q;
  logic [7:0] div_q;
  logic [1:0] sync_a_q, sync_b_q;
  logic [1:0] samp_a_q, samp_b_q;
  logic level_a_q, level_b_q;
  logic out_ff_q;
  logic wr_en, rd_setup;
  logic tick, base_tick;
  logic rise_a, fall_a, rise_b, fall_b;
  logic edge_a, edge_b, edge_a_raw;
  logic cap_a_mode, cap_b_mode;
  logic match_a, match_b, wrap;
  logic ovf_clear;
  tpp_mode_type mode;

  assign wr_en = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;
  assign mode = mode_of(timer_mode_control_q);
  assign cap_a_mode = capture_compare_control_q[CCC_A_CAPTURE];
  assign cap_b_mode = capture_compare_control_q[CCC_B_CAPTURE];

  // ************************************************************
  // Count clock selection
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else if (mode == TPP_STOP) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_comb begin
    case (prescaler_edge_select_q[PRS_CLK_LO +: 2])
      CLK_SEL_DIV1: base_tick = 1'b1;
      CLK_SEL_DIV4: base_tick = (div_q[1:0] == DIV4_TERM[1:0]);
      CLK_SEL_DIV256: base_tick = (div_q == DIV256_TERM);
      default: base_tick = 1'b0;
    endcase
  end

  // ************************************************************
  // Input synchronisers and noise filter
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_q <= 2'b00;
      sync_b_q <= 2'b00;
    end else begin
      sync_a_q <= {sync_a_q[0], trigger_input_a};
      sync_b_q <= {sync_b_q[0], trigger_input_b};
    end
  end

  // Filter samples at the count clock; external count mode samples each pclk
  logic filt_tick;
  assign filt_tick = (prescaler_edge_select_q[PRS_CLK_LO +: 2] == CLK_SEL_EDGE_A) |
                     base_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_a_q <= 2'b00;
      samp_b_q <= 2'b00;
      level_a_q <= 1'b0;
      level_b_q <= 1'b0;
    end else if (filt_tick) begin
      samp_a_q <= {samp_a_q[0], sync_a_q[1]};
      samp_b_q <= {samp_b_q[0], sync_b_q[1]};
      if (samp_a_q[1] == samp_a_q[0]) begin
        level_a_q <= samp_a_q[0];
      end
      if (samp_b_q[1] == samp_b_q[0]) begin
        level_b_q <= samp_b_q[0];
      end
    end
  end

  assign rise_a = filt_tick & (samp_a_q[1] == samp_a_q[0]) & samp_a_q[0] & ~level_a_q;
  assign fall_a = filt_tick & (samp_a_q[1] == samp_a_q[0]) & ~samp_a_q[0] & level_a_q;
  assign rise_b = filt_tick & (samp_b_q[1] == samp_b_q[0]) & samp_b_q[0] & ~level_b_q;
  assign fall_b = filt_tick & (samp_b_q[1] == samp_b_q[0]) & ~samp_b_q[0] & level_b_q;
  assign edge_a_raw = edge_hit(prescaler_edge_select_q[PRS_EDGE_A_LO +: 2], rise_a, fall_a);
  assign edge_a = (mode != TPP_STOP) & edge_a_raw;
  assign edge_b = (mode != TPP_STOP) &
                  edge_hit(prescaler_edge_select_q[PRS_EDGE_B_LO +: 2], rise_b, fall_b);

  assign tick = (mode != TPP_STOP) &
                ((prescaler_edge_select_q[PRS_CLK_LO +: 2] == CLK_SEL_EDGE_A) ?
                 edge_a_raw : base_tick);

  // ************************************************************
  // Counter and compare
  // ************************************************************
  assign match_a = tick & ~cap_a_mode & (timer_count_q == compare_capture_a_q);
  assign match_b = tick & ~cap_b_mode & (timer_count_q == compare_capture_b_q);
  assign wrap = tick & (timer_count_q == COUNT_ALL_ONES);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_q <= COUNT_ZERO;
    end else if (mode == TPP_STOP) begin
      timer_count_q <= COUNT_ZERO;
    end else if (mode == TPP_RESTART && edge_a) begin
      timer_count_q <= COUNT_ZERO;
    end else if (mode == TPP_CLEAR_A && match_a) begin
      timer_count_q <= COUNT_ZERO;
    end else if (tick) begin
      timer_count_q <= timer_count_q + 16'h0001;
    end
  end

  // Set wins over a software clear in the same cycle
  assign ovf_clear = wr_en && paddr == OFF_STATUS && pwdata[STS_OVERFLOW];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_q <= 1'b0;
    end else if (wrap) begin
      overflow_flag_q <= 1'b1;
    end else if (ovf_clear) begin
      overflow_flag_q <= 1'b0;
    end
  end

  // ************************************************************
  // Interrupt pulses
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_irq_a <= 1'b0;
      capture_irq_b <= 1'b0;
    end else begin
      // Match interrupt A; also on capture into A
      match_irq_a <= match_a | (cap_a_mode & edge_b);
      // Capture interrupt B; also on capture into B, triggered by the A input
      capture_irq_b <= match_b | (cap_b_mode & edge_a);
    end
  end

  // ************************************************************
  // Timer output
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ff_q <= 1'b0;
    end else if (mode == TPP_STOP) begin
      out_ff_q <= 1'b0;
      if (wr_en && paddr == OFF_OUTCTL && pwdata[OUT_FORCE_HIGH]) begin
        out_ff_q <= 1'b1;
      end
    end else if (match_b && output_control_q[OUT_B_INVERT]) begin
      // B match ends high pulse; width B plus one in TPP_CLEAR_A mode
      out_ff_q <= 1'b0;
    end else if (match_a && output_control_q[OUT_A_INVERT]) begin
      out_ff_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= output_control_q[OUT_ENABLE] & out_ff_q;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_control_q <= MODE_CODE_STOP;
      capture_compare_control_q <= 2'b00;
      prescaler_edge_select_q <= 8'h00;
      output_control_q <= 5'h00;
    end else if (wr_en) begin
      case (paddr)
        OFF_MODE: timer_mode_control_q <= pwdata[1:0];
        OFF_CCC: capture_compare_control_q <= pwdata[1:0];
        OFF_PRESCALE: prescaler_edge_select_q <= {pwdata[7:4], 2'b00, pwdata[1:0]};
        // Force high acts once, in stop mode only; force low has no effect; both read back as zero
        OFF_OUTCTL: output_control_q <= {pwdata[OUT_B_INVERT], 2'b00, pwdata[1:0]};
        default: ;
      endcase
    end
  end

  // Capture beats a software write landing in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_capture_a_q <= COUNT_ZERO;
    end else if (cap_a_mode && edge_b) begin
      compare_capture_a_q <= timer_count_q;
    end else if (wr_en && paddr == OFF_CCA) begin
      compare_capture_a_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_capture_b_q <= COUNT_ZERO;
    end else if (cap_b_mode && edge_a) begin
      compare_capture_b_q <= timer_count_q;
    end else if (wr_en && paddr == OFF_CCB) begin
      compare_capture_b_q <= pwdata[15:0];
    end
  end

  // ************************************************************
  // APB answer: no wait states, data loaded in setup
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RESET_WORD;
    end else begin
      pready <= rd_setup;
      pslverr <= 1'b0;
      prdata <= RESET_WORD;
      if (rd_setup) begin
        case (paddr)
          OFF_MODE: prdata <= {30'h0, timer_mode_control_q};
          OFF_CCC: prdata <= {30'h0, capture_compare_control_q};
          OFF_PRESCALE: prdata <= {24'h0, prescaler_edge_select_q};
          OFF_OUTCTL: prdata <= {27'h0, output_control_q};
          OFF_CCA: prdata <= {16'h0, compare_capture_a_q};
          OFF_CCB: prdata <= {16'h0, compare_capture_b_q};
          OFF_COUNT: prdata <= {16'h0, timer_count_q};
          OFF_STATUS: prdata <= {31'h0, overflow_flag_q};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule : tpp_timer

// [verif/tpp_timer_props.sv]
`timescale 1ns/1ns
// ************************************************************
// Port checker for the timer block
// ************************************************************
module tpp_timer_chk (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and events
  input wire logic trigger_input_a,
  input wire logic trigger_input_b,
  input wire logic timer_output_pin,
  input wire logic match_irq_a,
  input wire logic capture_irq_b
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  chk_err_unmap: assert property (psel && penable && (paddr > 8'h1C || paddr[1:0] != 2'b00)
    |-> pslverr)
    else $error("no error on unmapped address");
  chk_err_mapped: assert property (pready && paddr < 8'h20 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped address");
  chk_pin_rise: assert property (
    $rose(timer_output_pin) |-> $past(match_irq_a) || $past(match_irq_a, 2))
    else $error("output rose without A match");
  chk_irq_a_once: assert property (match_irq_a |=> !match_irq_a)
    else $error("A event longer than one cycle");
  chk_irq_b_once: assert property (capture_irq_b |=> !capture_irq_b)
    else $error("B event longer than one cycle");
endmodule : tpp_timer_chk

bind tpp_timer tpp_timer_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b),
  .timer_output_pin(timer_output_pin), .match_irq_a(match_irq_a),
  .capture_irq_b(capture_irq_b)
);

// [verif/tpp_pulse_peer.sv]
`timescale 1ns/1ns
// ************************************************************
// Pulse sources and output load
// ************************************************************
module tpp_pulse_peer (
  // Clock
  input wire logic pclk,
  // Pins
  input wire logic timer_output_pin,
  output logic trigger_input_a,
  output logic trigger_input_b
);
  int run_len = 0;
  int hi_len = 0;
  int per_len = 0;
  int since_rise = 0;
  logic pin_q = 1'b0;
  initial trigger_input_a = 1'b0;
  initial trigger_input_b = 1'b0;
  always @(posedge pclk) begin
    pin_q <= timer_output_pin;
    since_rise <= since_rise + 1;
    if (timer_output_pin === 1'b1) run_len <= run_len + 1;
    if (timer_output_pin === 1'b1 && pin_q === 1'b0) begin
      per_len <= since_rise;
      since_rise <= 1;
      run_len <= 1;
    end
    if (timer_output_pin === 1'b0 && pin_q === 1'b1) hi_len <= run_len;
  end
  task automatic pulse(input bit on_b, input int w);
    @(posedge pclk);
    if (on_b) trigger_input_b <= 1'b1;
    else trigger_input_a <= 1'b1;
    repeat (w) @(posedge pclk);
    if (on_b) trigger_input_b <= 1'b0;
    else trigger_input_a <= 1'b0;
  endtask : pulse
endmodule : tpp_pulse_peer

// [verif/tpp_timer_bench.sv]
`timescale 1ns/1ns
module tpp_timer_bench;
  import tpp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, trig_a, trig_b, pin, irq_a, irq_b;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int na = 0;
  int nb = 0;
  always #4 pclk = ~pclk;
  tpp_timer DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_input_a(trig_a), .trigger_input_b(trig_b), .timer_output_pin(pin),
    .match_irq_a(irq_a), .capture_irq_b(irq_b));
  tpp_pulse_peer PEER (.pclk(pclk), .timer_output_pin(pin), .trigger_input_a(trig_a),
    .trigger_input_b(trig_b));
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic close_out();
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // Hang guard, event counts
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (irq_a === 1'b1) na <= na + 1;
    if (irq_b === 1'b1) nb <= nb + 1;
    if (cyc == 90000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the slave; only the bench timeout ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd
  task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    check(what, r, exp);
  endtask : chk_rd
  task automatic gap_a(output int n);
    int k;
    k = 0;
    while (irq_a !== 1'b1 && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (irq_a !== 1'b1 && n < 2000);
  endtask : gap_a
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    logic [31:0] v0, v1, u0, u1;
    logic e;
    int g, m;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) chk_rd("reset", 8'(4 * i), RESET_WORD);
    apb(1'b0, 8'h20, 32'h0, v0, e);
    check("unmapped_rd", {31'h0, e}, 32'h1);
    apb(1'b1, 8'h20, 32'h5, v0, e);
    check("unmapped_wr", {31'h0, e}, 32'h1);
    apb(1'b0, 8'h05, 32'h0, v0, e);
    check("misaligned_rd", {31'h0, e}, 32'h1);
    wr(OFF_PRESCALE, 32'hFFFF_FFFF);
    chk_rd("prescale", OFF_PRESCALE, 32'h0000_00F3);
    wr(OFF_OUTCTL, 32'h0000_001B);
    chk_rd("outctl", OFF_OUTCTL, 32'h0000_0013);
    wr(OFF_COUNT, 32'h0000_1234);
    chk_rd("count_ro", OFF_COUNT, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_MODE, 32'h0);
      wr(OFF_CCC, 32'h0);
      wr(OFF_CCA, 32'h2);
      wr(OFF_PRESCALE, 32'(i));
      wr(OFF_MODE, 32'(MODE_CODE_CLEAR_A));
      gap_a(g);
      check("interval", 32'(g), 32'(i == 0 ? 3 : i == 1 ? 12 : 768));
    end
    chk_rd("no_ovf", OFF_STATUS, 32'h0);
    wr(OFF_MODE, 32'h0);
    wr(OFF_PRESCALE, 32'h0);
    wr(OFF_CCA, 32'hFFFF_FFFF);
    wr(OFF_MODE, 32'(MODE_CODE_CLEAR_A));
    repeat (65560) @(posedge pclk);
    chk_rd("ovf_set", OFF_STATUS, 32'h1);
    wr(OFF_STATUS, 32'h1);
    chk_rd("ovf_clr", OFF_STATUS, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(OFF_MODE, 32'h0);
      wr(OFF_CCC, 32'h0);
      wr(OFF_CCA, i ? 32'h9 : 32'h4);
      wr(OFF_CCB, i ? 32'h3 : 32'h0);
      wr(OFF_OUTCTL, 32'h13);
      wr(OFF_PRESCALE, 32'h0);
      wr(OFF_MODE, 32'(MODE_CODE_CLEAR_A));
      repeat (40) @(posedge pclk);
      check("ppg_high", 32'(PEER.hi_len), i ? 32'h4 : 32'h1);
      check("ppg_period", 32'(PEER.per_len), i ? 32'hA : 32'h5);
    end
    wr(OFF_OUTCTL, 32'h3);
    wr(OFF_CCB, 32'h6);
    @(posedge pclk);
    wr(OFF_OUTCTL, 32'h13);
    repeat (40) @(posedge pclk);
    check("ppg_new_high", 32'(PEER.hi_len), 32'h7);
    wr(OFF_MODE, 32'h0);
    wr(OFF_CCC, 32'h2);
    wr(OFF_PRESCALE, 32'h30);
    wr(OFF_MODE, 32'(MODE_CODE_FREE));
    m = nb;
    PEER.pulse(1'b0, 1);
    repeat (10) @(posedge pclk);
    check("glitch", 32'(nb - m), 32'h0);
    fork PEER.pulse(1'b0, 30); join_none
    repeat (12) @(posedge pclk);
    rd(OFF_CCB, v0);
    repeat (30) @(posedge pclk);
    rd(OFF_CCB, v1);
    check("width_a", v1 - v0, 32'd30);
    check("irq_b_count", 32'(nb - m), 32'h2);
    wr(OFF_MODE, 32'h0);
    wr(OFF_MODE, 32'(MODE_CODE_RESTART));
    fork PEER.pulse(1'b0, 25); join_none
    repeat (40) @(posedge pclk);
    rd(OFF_CCB, v0);
    check("restart", {31'h0, v0 >= 32'd24 && v0 <= 32'd26}, 32'h1);
    wr(OFF_MODE, 32'h0);
    wr(OFF_CCC, 32'h3);
    wr(OFF_PRESCALE, 32'hF0);
    wr(OFF_MODE, 32'(MODE_CODE_FREE));
    m = na;
    g = nb;
    fork PEER.pulse(1'b0, 30); PEER.pulse(1'b1, 40); join_none
    repeat (12) @(posedge pclk);
    rd(OFF_CCA, u0);
    rd(OFF_CCB, v0);
    repeat (40) @(posedge pclk);
    rd(OFF_CCA, u1);
    rd(OFF_CCB, v1);
    check("dual_a", u1 - u0, 32'd40);
    check("dual_b", v1 - v0, 32'd30);
    check("dual_irq_a", 32'(na - m), 32'h2);
    check("dual_irq_b", 32'(nb - g), 32'h2);
    // Count clock from filtered rising edges of trigger A
    wr(OFF_MODE, 32'h0);
    wr(OFF_CCC, 32'h0);
    wr(OFF_PRESCALE, 32'h13);
    wr(OFF_MODE, 32'(MODE_CODE_FREE));
    for (int i = 0; i < 3; i++) begin
      PEER.pulse(1'b0, 4);
      repeat (4) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
    chk_rd("edge_count", OFF_COUNT, 32'h3);
    close_out();
  end
endmodule : tpp_timer_bench
